//--- rtl/qpc_top.v
// quad 32-bit pulse counter bank with register port
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "qpc_defines.vh"
module qpc_top (
  input wire i_clk,
  input wire i_srst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [3:0] i_pulse,
  input wire [1:0] i_aux,
  input wire [1:0] i_reset_terminal,
  output reg [3:0] o_cmp_out
);
  // input map: pulse[0..3] per counter, up pulse in dual mode
  // aux[0]/aux[1]: down pulse or direction of counters one/four
  // reset_terminal[0]/[1]: cnt1_reset_terminal, cnt4_reset_terminal

  // forced mode: counters two and three only add
  // mode code three falls back to adding as well
  function [1:0] mode_of;
    input [5:0] cfg;
    input dual;
    begin
      if (!dual)
        mode_of = `QPC_M_ADD;
      else if (cfg[`QPC_F_MODE] == `QPC_M_DUAL)
        mode_of = `QPC_M_DUAL;
      else if (cfg[`QPC_F_MODE] == `QPC_M_UPDN)
        mode_of = `QPC_M_UPDN;
      else
        mode_of = `QPC_M_ADD;
    end
  endfunction

  // software registers
  // all four sets exist; the single-phase pair ignores the extras
  // presets wait here until a reload puts them in force
  reg [2:0] ctrl_q [0:3]; // clear, gate, soft reset
  reg [31:0] pre1_q [0:3]; // preset one (single preset for 2, 3)
  reg [31:0] pre2_q [0:3]; // preset two (counters one, four)
  reg [31:0] rstv_q [0:3]; // reset value (counters one, four)
  reg [5:0] cfg_q [0:3]; // mode, keep, terminal enable, cmp enable
  reg [31:0] snap_q [0:3]; // per-scan copy of the live value

  // bus decode
  // word offsets only; the low two address bits must be zero
  // a write of any value to the scan slot ends a program scan
  wire [2:0] cidx_w; // counter block index
  wire [2:0] ridx_w; // register within block
  wire in_blk_w; // address inside a counter block
  wire scan_w; // end of program scan
  assign cidx_w = i_addr[7:5];
  assign ridx_w = i_addr[4:2];
  assign in_blk_w = (i_addr[7] == 1'b0) && (i_addr[1:0] == 2'h0);
  assign scan_w = i_wr && (i_addr == `QPC_SCAN);

  // synchronised terminals
  // bits 3:0 pulse, 5:4 aux, 7:6 reset terminals
  // a change counts only once stages two and three agree
  wire [7:0] lvl_w; // stable levels
  wire [7:0] rise_w; // one-cycle rising edges

  qpc_sync #(
    .W(8)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin({i_reset_terminal, i_aux, i_pulse}),
    .o_level_q(lvl_w),
    .o_rise_q(rise_w)
  );

  // per-counter live values and events, flattened
  // event bits per counter follow the status word layout
  // flags gather over a scan and clear at the following scan write
  wire [127:0] cur_w; // live values
  wire [19:0] ev_w; // five events per counter
  wire [19:0] flag_w; // one-scan status flags

  qpc_flag #(
    .W(20)
  ) u_flag (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_event(ev_w),
    .i_scan(scan_w),
    .o_flag_q(flag_w)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
      // counters one and four have the reversible extras
      // lane select for the aux and terminal pins of this counter
      // the single-phase pair ties those lanes off
      localparam DUAL = (gi == 0) || (gi == 3);
      localparam AX = (gi == 0) ? 0 : 1;

      reg [31:0] val_q; // live count
      reg [31:0] act1_q; // preset one in force
      reg [31:0] act2_q; // preset two in force
      reg [4:0] ev_q; // single-cycle events

      wire [1:0] mode_w;
      wire up_e; // pulse or up-pulse rise
      wire dn_e; // down-pulse rise
      wire dir_w; // direction level
      wire hw_e; // terminal reset event
      wire gate_w;
      wire soft_w;
      wire inc_w;
      wire dec_w;
      wire keep1_w;
      wire keep2_w;
      wire [31:0] rv_w; // value loaded on reload
      wire [31:0] nup_w;
      wire [31:0] ndn_w;

      assign mode_w = mode_of(cfg_q[gi], DUAL);
      assign up_e = rise_w[gi];
      assign dn_e = DUAL ? rise_w[4 + AX] : 1'b0;
      assign dir_w = DUAL ? lvl_w[4 + AX] : 1'b1;
      assign hw_e = DUAL ? (rise_w[6 + AX] & cfg_q[gi][`QPC_F_HWEN]) : 1'b0;
      assign gate_w = ctrl_q[gi][`QPC_C_GATE];
      assign soft_w = ctrl_q[gi][`QPC_C_SRST];
      assign keep1_w = DUAL ? cfg_q[gi][`QPC_F_KEEP1] : 1'b0;
      assign keep2_w = DUAL ? cfg_q[gi][`QPC_F_KEEP2] : 1'b0;
      assign rv_w = DUAL ? rstv_q[gi] : 32'h00000000;
      assign nup_w = val_q + 32'h00000001;
      assign ndn_w = val_q - 32'h00000001;

      // count direction per mode, all gated
      // both strobes together in dual mode cancel out
      assign inc_w = gate_w & (
        (mode_w == `QPC_M_DUAL) ? (up_e & ~dn_e) :
        (mode_w == `QPC_M_UPDN) ? (up_e & dir_w) :
        up_e);
      assign dec_w = gate_w & (
        (mode_w == `QPC_M_DUAL) ? (dn_e & ~up_e) :
        (mode_w == `QPC_M_UPDN) ? (up_e & ~dir_w) :
        1'b0);

      // counting, comparison and reload
      // priority: terminal reset, soft reset, then one count step
      // a count step compares the next value, not the present one
      // so a hit shows on the same edge that stores the value
      // events last one cycle and are gathered per scan downstream
      always @(posedge i_clk) begin
        ev_q <= 5'h00;
        if (i_srst) begin
          val_q <= `QPC_RSTV_RST;
          act1_q <= `QPC_PRE_RST;
          act2_q <= `QPC_PRE_RST;
        end else if (hw_e) begin
          // terminal reset: reload, resample presets, flag
          val_q <= rv_w;
          act1_q <= pre1_q[gi];
          act2_q <= pre2_q[gi];
          ev_q[`QPC_S_HWR] <= 1'b1;
        end else if (soft_w) begin
          // soft reset holds the reload value, no flag
          val_q <= rv_w;
          act1_q <= pre1_q[gi];
          act2_q <= pre2_q[gi];
        end else if (inc_w) begin
          // preset one first, then preset two, then the top
          if (nup_w == act1_q) begin
            ev_q[`QPC_S_P1] <= 1'b1;
            if (keep1_w) begin
              val_q <= nup_w;
            end else begin
              val_q <= rv_w;
              act1_q <= pre1_q[gi];
              act2_q <= pre2_q[gi];
            end
          end else if (DUAL && (nup_w == act2_q)) begin
            ev_q[`QPC_S_P2] <= 1'b1;
            if (keep2_w) begin
              val_q <= nup_w;
            end else begin
              val_q <= rv_w;
              act1_q <= pre1_q[gi];
              act2_q <= pre2_q[gi];
            end
          end else if (DUAL && (nup_w == `QPC_MAXV)) begin
            // reaching the top value is the overflow point
            // overflow fires and the count restarts at the reload value
            ev_q[`QPC_S_OVF] <= 1'b1;
            val_q <= rv_w;
            act1_q <= pre1_q[gi];
            act2_q <= pre2_q[gi];
          end else begin
            val_q <= nup_w;
          end
        end else if (dec_w) begin
          // zero is checked before the presets on the way down
          if (ndn_w == 32'h00000000) begin
            // reached zero going down: underflow and reload
            ev_q[`QPC_S_UNF] <= 1'b1;
            val_q <= rv_w;
            act1_q <= pre1_q[gi];
            act2_q <= pre2_q[gi];
          end else if (ndn_w == act1_q) begin
            ev_q[`QPC_S_P1] <= 1'b1;
            if (keep1_w) begin
              val_q <= ndn_w;
            end else begin
              val_q <= rv_w;
              act1_q <= pre1_q[gi];
              act2_q <= pre2_q[gi];
            end
          end else if (ndn_w == act2_q) begin
            ev_q[`QPC_S_P2] <= 1'b1;
            if (keep2_w) begin
              val_q <= ndn_w;
            end else begin
              val_q <= rv_w;
              act1_q <= pre1_q[gi];
              act2_q <= pre2_q[gi];
            end
          end else begin
            val_q <= ndn_w;
          end
        end
      end

      assign cur_w[32 * gi +: 32] = val_q;
      assign ev_w[5 * gi +: 5] = ev_q;
    end
  endgenerate

  // comparison outputs: set by any hit, cleared by clear bit
  // a hit in the same cycle as the clear bit keeps the output on
  // outputs stay low unless the counter's cmp enable is set
  integer k;
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_cmp_out <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (cfg_q[k][`QPC_F_CMPEN] && (ev_w[5 * k + 1 +: 4] != 4'h0)) begin
          o_cmp_out[k] <= 1'b1;
        end else if (ctrl_q[k][`QPC_C_CLR]) begin
          o_cmp_out[k] <= 1'b0;
        end
      end
    end
  end

  // per-scan value copy
  // software sees the count as of the last scan write
  // the live value keeps moving between scans
  integer s;
  always @(posedge i_clk) begin
    if (i_srst) begin
      for (s = 0; s < 4; s = s + 1) begin
        snap_q[s] <= 32'h00000000;
      end
    end else if (scan_w) begin
      for (s = 0; s < 4; s = s + 1) begin
        snap_q[s] <= cur_w[32 * s +: 32];
      end
    end
  end

  // register writes
  // status and current-value slots take no writes
  // unmapped offsets are dropped silently
  integer w;
  always @(posedge i_clk) begin
    if (i_srst) begin
      for (w = 0; w < 4; w = w + 1) begin
        ctrl_q[w] <= 3'h0;
        pre1_q[w] <= `QPC_PRE_RST;
        pre2_q[w] <= `QPC_PRE_RST;
        rstv_q[w] <= `QPC_RSTV_RST;
        cfg_q[w] <= `QPC_CFG_RST;
      end
    end else if (i_wr && in_blk_w && (cidx_w < 3'h4)) begin
      case (ridx_w)
        `QPC_CTRL: begin
          ctrl_q[cidx_w[1:0]] <= i_wdata[2:0];
        end
        `QPC_PRE1: begin
          pre1_q[cidx_w[1:0]] <= i_wdata;
        end
        `QPC_PRE2: begin
          pre2_q[cidx_w[1:0]] <= i_wdata;
        end
        `QPC_RSTV: begin
          rstv_q[cidx_w[1:0]] <= i_wdata;
        end
        `QPC_CFG: begin
          // counters two and three keep only cmp enable
          // mode, keep and terminal bits are dropped for them
          if ((cidx_w == 3'h0) || (cidx_w == 3'h3))
            cfg_q[cidx_w[1:0]] <= i_wdata[5:0];
          else
            cfg_q[cidx_w[1:0]] <= i_wdata[5:0] & 6'h20;
        end
        default: begin
          // read-only or unused slot
        end
      endcase
    end
  end

  // ordinary-input view of unused terminals
  // a terminal in use by its counter reads as zero here
  // levels come from the synchroniser, never the raw pin
  wire [3:0] pins_w;
  assign pins_w[0] = (mode_of(cfg_q[0], 1'b1) == `QPC_M_ADD) ? lvl_w[4] : 1'b0;
  assign pins_w[1] = (mode_of(cfg_q[3], 1'b1) == `QPC_M_ADD) ? lvl_w[5] : 1'b0;
  assign pins_w[2] = cfg_q[0][`QPC_F_HWEN] ? 1'b0 : lvl_w[6];
  assign pins_w[3] = cfg_q[3][`QPC_F_HWEN] ? 1'b0 : lvl_w[7];

  // read data, valid the cycle after the strobe only
  // idle cycles return zero so a stale word never lingers
  // unaligned or unmapped reads also answer zero
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (!i_rd) begin
      o_rdata <= 32'h00000000;
    end else if (i_addr == `QPC_PINS) begin
      o_rdata <= {28'h0000000, pins_w};
    end else if (in_blk_w && (cidx_w < 3'h4)) begin
      case (ridx_w)
        `QPC_CTRL: o_rdata <= {29'h00000000, ctrl_q[cidx_w[1:0]]};
        `QPC_STAT: o_rdata <= {27'h0000000, flag_w[5 * cidx_w +: 5]};
        `QPC_CURV: o_rdata <= snap_q[cidx_w[1:0]];
        `QPC_PRE1: o_rdata <= pre1_q[cidx_w[1:0]];
        `QPC_PRE2: o_rdata <= pre2_q[cidx_w[1:0]];
        `QPC_RSTV: o_rdata <= rstv_q[cidx_w[1:0]];
        `QPC_CFG: o_rdata <= {26'h0000000, cfg_q[cidx_w[1:0]]};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule

//--- rtl/qpc_defines.vh
// constants for the quad pulse counter bank
`ifndef QPC_DEFINES_VH
`define QPC_DEFINES_VH
// register map: counter n block at n * stride
`define QPC_STRIDE 8'h20
`define QPC_CTRL 3'h0
`define QPC_STAT 3'h1
`define QPC_CURV 3'h2
`define QPC_PRE1 3'h3
`define QPC_PRE2 3'h4
`define QPC_RSTV 3'h5
`define QPC_CFG 3'h6
// global registers
`define QPC_SCAN 8'h80
`define QPC_PINS 8'h84
// control bits
`define QPC_C_CLR 0
`define QPC_C_GATE 1
`define QPC_C_SRST 2
// config fields
`define QPC_F_MODE 1:0
`define QPC_F_KEEP1 2
`define QPC_F_KEEP2 3
`define QPC_F_HWEN 4
`define QPC_F_CMPEN 5
// modes
`define QPC_M_ADD 2'h0
`define QPC_M_DUAL 2'h1
`define QPC_M_UPDN 2'h2
// status bits
`define QPC_S_HWR 0
`define QPC_S_P1 1
`define QPC_S_P2 2
`define QPC_S_OVF 3
`define QPC_S_UNF 4
// reset values
`define QPC_PRE_RST 32'hffffffff
`define QPC_RSTV_RST 32'h00000000
`define QPC_CFG_RST 6'h00
`define QPC_MAXV 32'hffffffff
`endif

//--- rtl/qpc_sync.v
// three-stage input synchroniser with stable level and rise pulse
`timescale 1ns/100ps
module qpc_sync #(
  parameter W = 8
) (
  input wire i_clk,
  input wire i_srst,
  input wire [W-1:0] i_pin,
  output reg [W-1:0] o_level_q,
  output reg [W-1:0] o_rise_q
);
  reg [W-1:0] s1_q; // first stage, read only by s2
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree_w;
  wire [W-1:0] level_d;

  // level moves only when stages two and three agree
  assign agree_w = ~(s2_q ^ s3_q);
  assign level_d = (agree_w & s3_q) | (~agree_w & o_level_q);

  // sampling chain and edge detect
  always @(posedge i_clk) begin
    if (i_srst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      o_level_q <= {W{1'b0}};
      o_rise_q <= {W{1'b0}};
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_level_q <= level_d;
      o_rise_q <= level_d & ~o_level_q;
    end
  end
endmodule

//--- rtl/qpc_flag.v
// one-scan status flags gathered from single-cycle events
`timescale 1ns/100ps
module qpc_flag #(
  parameter W = 20
) (
  input wire i_clk,
  input wire i_srst,
  input wire [W-1:0] i_event,
  input wire i_scan,
  output reg [W-1:0] o_flag_q
);
  reg [W-1:0] pend_q; // events seen during the current scan

  // events collect in pend, show for exactly one scan
  always @(posedge i_clk) begin
    if (i_srst) begin
      pend_q <= {W{1'b0}};
      o_flag_q <= {W{1'b0}};
    end else if (i_scan) begin
      o_flag_q <= pend_q | i_event;
      pend_q <= {W{1'b0}};
    end else begin
      pend_q <= pend_q | i_event;
    end
  end
endmodule

//--- bench/qpc_pulse_src.sv
// pulse source model driving the counter pins
`timescale 1ns/100ps
module qpc_pulse_src (
  input wire i_clk,
  output reg [3:0] o_pulse,
  output reg [1:0] o_aux,
  output reg [1:0] o_rst
);
  // all pins idle low at time zero
  initial begin
    o_pulse = 4'h0;
    o_aux = 2'h0;
    o_rst = 2'h0;
  end
  // n pulses on the masked lines, long enough high and low to pass the synchroniser
  task pulse(input [3:0] up, input [1:0] dn, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge i_clk);
      o_pulse <= o_pulse | up;
      o_aux <= o_aux | dn;
      repeat (4) @(posedge i_clk);
      o_pulse <= o_pulse & ~up;
      o_aux <= o_aux & ~dn;
      repeat (6) @(posedge i_clk);
    end
  endtask
  // direction and reset terminal levels, then let them settle
  task level(input [1:0] dir, input [1:0] rst);
    @(posedge i_clk);
    o_aux <= dir;
    o_rst <= rst;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

//--- bench/qpc_top_props.sv
// port checker for the quad pulse counter bank
`timescale 1ns/100ps
module qpc_props (
  input wire i_clk,
  input wire i_srst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [3:0] i_pulse,
  input wire [1:0] i_aux,
  input wire [1:0] i_reset_terminal,
  input wire [3:0] o_cmp_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  reg [7:0] pins_q; // last pin levels
  reg [3:0] quiet_q; // cycles since a pin moved, saturating
  // a comparison output may only rise shortly after pin activity
  always @(posedge i_clk) begin
    pins_q <= {i_pulse, i_aux, i_reset_terminal};
    if (i_srst || pins_q != {i_pulse, i_aux, i_reset_terminal}) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence s_wr_ctrl;
    i_wr && i_addr == 8'h00;
  endsequence
  sequence s_rd_ctrl;
    i_rd && i_addr == 8'h00;
  endsequence
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  chk_unaligned_zero: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
    else $error("unaligned read not zero");
  chk_ctrl_back: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> o_rdata == {29'h0, $past(i_wdata[2:0], 2)})
    else $error("control bits not read back");
  chk_stat_single: assert property (i_rd && (i_addr == 8'h24 || i_addr == 8'h44) |=> (o_rdata & 32'hfffffffd) == 32'h0)
    else $error("extra status bits on single preset counter");
  chk_stat_width: assert property (i_rd && i_addr[4:0] == 5'h04 && !i_addr[7] |=> o_rdata[31:5] == 27'h0)
    else $error("status word too wide");
  chk_cfg_single: assert property (i_rd && (i_addr == 8'h38 || i_addr == 8'h58) |=> o_rdata[4:0] == 5'h0)
    else $error("mode bits stored on single phase counter");
  chk_pins_width: assert property (i_rd && i_addr == 8'h84 |=> o_rdata[31:4] == 28'h0)
    else $error("pin word too wide");
  chk_cmp_cause: assert property ((o_cmp_out & ~$past(o_cmp_out)) != 4'h0 |-> quiet_q < 4'ha)
    else $error("comparison output rose without a pulse");
endmodule
bind qpc_top qpc_props u_props (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_pulse(i_pulse),
  .i_aux(i_aux),
  .i_reset_terminal(i_reset_terminal),
  .o_cmp_out(o_cmp_out)
);

//--- bench/tb_qpc_top.sv
// self-checking bench for the quad pulse counter bank
`timescale 1ns/100ps
module tb_qpc_top;
  reg i_clk = 1'b0;
  reg i_srst = 1'b1;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  wire [31:0] o_rdata;
  wire [3:0] pulse; // pins from the source model
  wire [1:0] aux;
  wire [1:0] rst_pin;
  wire [3:0] o_cmp_out;
  integer n_fail = 0;
  integer checked = 0;
  qpc_top u_dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_pulse(pulse),
    .i_aux(aux),
    .i_reset_terminal(rst_pin),
    .o_cmp_out(o_cmp_out)
  );
  qpc_pulse_src u_src (
    .i_clk(i_clk),
    .o_pulse(pulse),
    .o_aux(aux),
    .o_rst(rst_pin)
  );
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  task stop_test;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus strobes: each task starts just after a rising edge
  task go(input integer n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), e, o_rdata);
    @(posedge i_clk);
  endtask
  task scan;
    wr(8'h80, 32'h0);
    go(1);
  endtask
  task pls(input [3:0] up, input [1:0] dn, input integer n);
    go(1);
    u_src.pulse(up, dn, n);
  endtask
  // configure, soft reset to sample presets, refresh snapshot
  task setc(input [7:0] b, input [7:0] cfg, input [31:0] p1, input [31:0] rv);
    wr(b + 8'h18, {24'h0, cfg});
    wr(b + 8'h0c, p1);
    wr(b + 8'h14, rv);
    wr(b, 32'h6);
    wr(b, 32'h2);
    scan;
  endtask
  // reset values, refused places, control readback
  task t_regs;
    integer n;
    for (n = 0; n < 4; n = n + 1) begin
      rdc({n[1:0], 5'h0c}, 32'hffffffff);
      rdc({n[1:0], 5'h18}, 32'h0);
    end
    rdc(8'h1c, 32'h0);
    rdc(8'h02, 32'h0);
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h7);
    rdc(8'h00, 32'h7);
    rdc(8'h08, 32'h0);
    wr(8'h00, 32'h0);
  endtask
  // adding mode hit on every counter, latch, clear, gate off
  task t_add;
    integer n;
    reg [7:0] b;
    reg [31:0] st;
    for (n = 0; n < 4; n = n + 1) begin
      b = {n[1:0], 5'h00};
      st = (n == 0 || n == 3) ? 32'h1 : 32'h0;
      setc(b, (n == 0 || n == 3) ? 8'h20 : 8'h3f, 32'h4, 32'h1);
      rdc(b + 8'h18, 32'h20);
      rdc(b + 8'h08, st);
      pls(4'h1 << n, 2'h0, 4 - st);
      scan;
      rdc(b + 8'h08, st);
      chk("cmp", 32'h1, o_cmp_out[n]);
      rdc(b + 8'h04, 32'h2);
      scan;
      rdc(b + 8'h04, 32'h0);
      wr(b, 32'h3);
      go(2);
      chk("cmp", 32'h0, o_cmp_out[n]);
      wr(b, 32'h0);
      pls(4'h1 << n, 2'h0, 2);
      scan;
      rdc(b + 8'h08, st);
    end
  endtask
  // keep chain through preset two to overflow
  task t_keep;
    integer i;
    reg [31:0] ev [0:3];
    reg [31:0] fl [0:3];
    ev[0] = 32'hfffffffc;
    ev[1] = 32'hfffffffd;
    ev[2] = 32'hfffffffe;
    ev[3] = 32'hfffffffb;
    fl[0] = 32'h2;
    fl[1] = 32'h4;
    fl[2] = 32'h0;
    fl[3] = 32'h8;
    wr(8'h10, 32'hfffffffd);
    setc(8'h00, 8'h2c, 32'hfffffffc, 32'hfffffffb);
    for (i = 0; i < 4; i = i + 1) begin
      pls(4'h1, 2'h0, 1);
      if (i == 0) rdc(8'h08, 32'hfffffffb);
      scan;
      rdc(8'h08, ev[i]);
      rdc(8'h04, fl[i]);
    end
  endtask
  // dual pulse on counter four: down, up, both, preset while down, underflow
  task t_dual;
    integer i;
    reg [3:0] up [0:4];
    reg [1:0] dn [0:4];
    reg [31:0] ev [0:4];
    up = '{4'h0, 4'h8, 4'h8, 4'h0, 4'h0};
    dn = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h2};
    ev = '{32'h4, 32'h5, 32'h5, 32'h4, 32'h5};
    setc(8'h60, 8'h21, 32'h3, 32'h5);
    for (i = 0; i < 5; i = i + 1) begin
      pls(up[i], dn[i], 1);
      scan;
      rdc(8'h68, ev[i]);
    end
    rdc(8'h64, 32'h2);
    setc(8'h60, 8'h21, 32'h3, 32'h1);
    pls(4'h0, 2'h2, 1);
    scan;
    rdc(8'h68, 32'h1);
    rdc(8'h64, 32'h10);
  endtask
  // direction select on counter one
  task t_updn;
    setc(8'h00, 8'h02, 32'hffffffff, 32'h0a);
    u_src.level(2'h1, 2'h0);
    pls(4'h1, 2'h0, 2);
    scan;
    rdc(8'h08, 32'h0c);
    u_src.level(2'h0, 2'h0);
    pls(4'h1, 2'h0, 3);
    scan;
    rdc(8'h08, 32'h09);
  endtask
  // plain input pins, terminal reset flag, soft reset without flag
  task t_hw;
    setc(8'h00, 8'h00, 32'hffffffff, 32'h3);
    u_src.level(2'h1, 2'h1);
    rdc(8'h84, 32'h5);
    u_src.level(2'h0, 2'h0);
    wr(8'h18, 32'h10);
    pls(4'h1, 2'h0, 2);
    u_src.level(2'h0, 2'h1);
    u_src.level(2'h0, 2'h0);
    scan;
    rdc(8'h08, 32'h3);
    rdc(8'h04, 32'h1);
    pls(4'h1, 2'h0, 1);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h2);
    scan;
    rdc(8'h08, 32'h3);
    rdc(8'h04, 32'h0);
  endtask
  initial begin
    #3000000;
    n_fail = n_fail + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    t_regs;
    t_add;
    t_keep;
    t_dual;
    t_updn;
    t_hw;
    go(2);
    stop_test;
  end
endmodule
